/* File: crb1_ctrl.sv */
// crb1_ctrl: control and status of receive buffer 1 with avalon-mm slave
// assumes: receive engine offers one-cycle frame pulses on clk; software on avalon
// Functional notes
// - mode 11 stores every frame, also those received with errors.
// - mode 10 stores only good extended frames, mode 01 only good standard frames.
// - mode 00 stores every good frame of either format.
// - the filter-hit field holds the filter code of the latest stored frame.
// - codes 5 to 2 name filters five to two, and codes 6 and 7 never appear.
// - codes 1 and 0 appear only while buffer-0 overflow into this buffer is on.
`timescale 1ns/1ps
`default_nettype none
module crb1_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // receive engine
  input wire crb1_pkg::crb1_frame_type rx_frame,
  output logic rx_store,
  output logic buffer_full_flag,
  output logic buffer0_overflow_enable,
  // interrupt
  output logic irq
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic buffer_full_reg;
  logic [1:0] buffer_mode_reg;
  logic remote_request_seen_reg;
  logic [2:0] filter_hit_code_reg;
  logic overflow_enable_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_mask_reg;
  logic ack_reg;
  logic accept;
  logic wr_ctrl;
  logic wr_status;
  logic [7:0] ctrl_view;

  crb1_accept accept_unit (
    .frame(rx_frame),
    .mode(buffer_mode_reg),
    .overflow_enable(overflow_enable_reg),
    .accept(accept)
  );

  // a full buffer is never overwritten; the frame is reported as dropped
  assign rx_store = accept && !buffer_full_reg;
  assign buffer_full_flag = buffer_full_reg;
  assign buffer0_overflow_enable = overflow_enable_reg;
  assign irq = |(irq_status_reg & irq_mask_reg);

  // ----------------------------------------------------------------------
  // bus handshake: one wait cycle, answer on the second edge
  // ----------------------------------------------------------------------
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign wr_ctrl = avs_write && ack_reg && (avs_address == crb1_pkg::ctrl_offset);
  assign wr_status = avs_write && ack_reg && (avs_address == crb1_pkg::irq_status_offset);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      ack_reg <= 1'b0;
    else
      ack_reg <= (avs_read || avs_write) && !ack_reg;
  end

  // ----------------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      buffer_full_reg <= crb1_pkg::ctrl_reset[crb1_pkg::full_bit];
      buffer_mode_reg <= crb1_pkg::ctrl_reset[crb1_pkg::mode_high_bit:crb1_pkg::mode_low_bit];
      remote_request_seen_reg <= crb1_pkg::ctrl_reset[crb1_pkg::remote_bit];
      filter_hit_code_reg <= crb1_pkg::ctrl_reset[crb1_pkg::hit_msb:0];
    end
    else
    begin
      if (wr_ctrl)
        buffer_mode_reg <= avs_writedata[crb1_pkg::mode_high_bit:crb1_pkg::mode_low_bit];
      // store wins over a clear in the same cycle
      if (rx_store)
        buffer_full_reg <= 1'b1;
      else if (wr_ctrl && !avs_writedata[crb1_pkg::full_bit])
        buffer_full_reg <= 1'b0;
      if (rx_store)
      begin
        filter_hit_code_reg <= rx_frame.filter;
        remote_request_seen_reg <= rx_frame.remote;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      overflow_enable_reg <= 1'b0;
    else if (avs_write && ack_reg && (avs_address == crb1_pkg::overflow_cfg_offset))
      overflow_enable_reg <= avs_writedata[0];
  end

  // ----------------------------------------------------------------------
  // interrupts: write one to clear, set wins
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_status_reg <= crb1_pkg::irq_reset;
      irq_mask_reg <= crb1_pkg::irq_reset;
    end
    else
    begin
      irq_status_reg[crb1_pkg::irq_stored_bit] <= rx_store ||
        (irq_status_reg[crb1_pkg::irq_stored_bit] &&
        !(wr_status && avs_writedata[crb1_pkg::irq_stored_bit]));
      irq_status_reg[crb1_pkg::irq_dropped_bit] <= (accept && buffer_full_reg) ||
        (irq_status_reg[crb1_pkg::irq_dropped_bit] &&
        !(wr_status && avs_writedata[crb1_pkg::irq_dropped_bit]));
      if (avs_write && ack_reg && (avs_address == crb1_pkg::irq_mask_offset))
        irq_mask_reg <= avs_writedata[1:0];
    end
  end

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  assign ctrl_view = {buffer_full_reg, buffer_mode_reg, 1'b0, remote_request_seen_reg, filter_hit_code_reg};

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && !ack_reg)
    begin
      unique case (avs_address)
        crb1_pkg::ctrl_offset: avs_readdata <= {24'h00_0000, ctrl_view};
        crb1_pkg::irq_status_offset: avs_readdata <= {30'h0000_0000, irq_status_reg};
        crb1_pkg::irq_mask_offset: avs_readdata <= {30'h0000_0000, irq_mask_reg};
        crb1_pkg::overflow_cfg_offset: avs_readdata <= {31'h0000_0000, overflow_enable_reg};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : crb1_ctrl
`default_nettype wire

/* File: crb1_pkg.sv */
// crb1_pkg: constants and carrier types for the receive buffer 1 control block
// assumes: one 50 mhz clock domain, avalon-mm register access with 32-bit words
package crb1_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [3:0] ctrl_offset = 4'h0;
  localparam logic [3:0] irq_status_offset = 4'h4;
  localparam logic [3:0] irq_mask_offset = 4'h8;
  localparam logic [3:0] overflow_cfg_offset = 4'hc;

  // ----------------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------------
  localparam int full_bit = 7;
  localparam int mode_high_bit = 6;
  localparam int mode_low_bit = 5;
  localparam int remote_bit = 3;
  localparam int hit_msb = 2;
  localparam logic [7:0] ctrl_reset = 8'h00;

  // ----------------------------------------------------------------------
  // buffer modes
  // ----------------------------------------------------------------------
  localparam logic [1:0] mode_all_valid = 2'h0;
  localparam logic [1:0] mode_std_only = 2'h1;
  localparam logic [1:0] mode_ext_only = 2'h2;
  localparam logic [1:0] mode_all_any = 2'h3;

  // ----------------------------------------------------------------------
  // filter hit codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] hit_filter_one = 3'h1;
  localparam logic [2:0] hit_filter_five = 3'h5;

  // ----------------------------------------------------------------------
  // interrupt status bits
  // ----------------------------------------------------------------------
  localparam int irq_stored_bit = 0;
  localparam int irq_dropped_bit = 1;
  localparam logic [1:0] irq_reset = 2'h0;

  // frame offered by the receive engine
  typedef struct packed {
    logic valid;
    logic has_error;
    logic extended;
    logic remote;
    logic [2:0] filter;
  } crb1_frame_type;

endpackage : crb1_pkg

/* File: crb1_accept.sv */
// crb1_accept: acceptance decision for one offered frame
// assumes: frame fields stand in the same cycle as valid
`timescale 1ns/1ps
`default_nettype none
module crb1_accept (
  // frame and settings
  input wire crb1_pkg::crb1_frame_type frame,
  input wire logic [1:0] mode,
  input wire logic overflow_enable,
  // decision
  output logic accept
);

  logic mode_ok;
  logic filter_ok;

  always_comb
  begin
    unique case (mode)
      crb1_pkg::mode_all_any: mode_ok = 1'b1;
      crb1_pkg::mode_ext_only: mode_ok = !frame.has_error && frame.extended;
      crb1_pkg::mode_std_only: mode_ok = !frame.has_error && !frame.extended;
      crb1_pkg::mode_all_valid: mode_ok = !frame.has_error;
    endcase
  end

  // reserved codes 6 and 7 are rejected here; filters 0 and 1 only via overflow
  assign filter_ok = (frame.filter <= crb1_pkg::hit_filter_five) &&
    ((frame.filter > crb1_pkg::hit_filter_one) || overflow_enable);
  assign accept = frame.valid && mode_ok && filter_ok;

endmodule : crb1_accept
`default_nettype wire

/* File: crb1_ctrl_asserts.sv */
// crb1_ctrl_asserts: port-level checks of receive buffer 1 control
// assumes: bound to crb1_ctrl, one clock, mode written at the control offset
`timescale 1ns/1ps
`default_nettype none
module crb1_ctrl_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // avalon-mm
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // receive engine
  input wire crb1_pkg::crb1_frame_type rx_frame,
  input wire logic rx_store,
  input wire logic buffer_full_flag,
  input wire logic buffer0_overflow_enable,
  input wire logic irq
);
  logic [1:0] mode_reg;
  logic [2:0] hit_reg;
  logic good;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // shadows give the checks the register state that has no port
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst) mode_reg <= 2'h0;
    else if (avs_write && !avs_waitrequest && avs_address == crb1_pkg::ctrl_offset) mode_reg <= avs_writedata[6:5];
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst) hit_reg <= 3'h0;
    else if (rx_store) hit_reg <= rx_frame.filter;
  assign good = rx_frame.valid && !buffer_full_flag && (rx_frame.filter[2] ^ rx_frame.filter[1]);
  all_frames_a: assert property (good && mode_reg == 2'h3 |-> rx_store)
    else $error("mode 3 frame not stored");
  format_only_a: assert property (rx_store && mode_reg != 2'h3 |-> !rx_frame.has_error &&
    (mode_reg == 2'h0 || rx_frame.extended == mode_reg[1])) else $error("frame stored against mode");
  any_valid_a: assert property (good && !rx_frame.has_error && mode_reg == 2'h0 |-> rx_store)
    else $error("good frame not stored in mode 0");
  hit_read_a: assert property (avs_read && !avs_waitrequest && avs_address == crb1_pkg::ctrl_offset
    && !$past(rx_store) |-> avs_readdata[2:0] == hit_reg) else $error("filter hit not latest");
  no_reserved_a: assert property (rx_store |-> !(rx_frame.filter[2] && rx_frame.filter[1]))
    else $error("reserved filter code stored");
  low_filters_a: assert property (rx_store && rx_frame.filter[2:1] == 2'h0 |-> buffer0_overflow_enable)
    else $error("filter 0 or 1 without overflow");
  full_set_a: assert property (rx_store |-> !buffer_full_flag ##1 buffer_full_flag)
    else $error("full flag not set by store");
endmodule : crb1_ctrl_asserts
bind crb1_ctrl crb1_ctrl_asserts chk (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .rx_frame(rx_frame), .rx_store(rx_store),
  .buffer_full_flag(buffer_full_flag), .buffer0_overflow_enable(buffer0_overflow_enable), .irq(irq));
`default_nettype wire

/* File: crb1_engine_model.sv */
// crb1_engine_model: receive engine offering frames to buffer 1
// assumes: the bench calls offer; one clock
`timescale 1ns/1ps
`default_nettype none
module crb1_engine_model (
  // clock
  input wire logic clk,
  // frame and decision
  output var crb1_pkg::crb1_frame_type rx_frame,
  input wire logic rx_store
);
  logic taken;
  initial rx_frame = 7'h2a;
  task offer(input logic e, input logic x, input logic [2:0] f);
    @(posedge clk);
    rx_frame <= {1'b1, e, x, f[0], f};
    #1 taken = rx_store;
    @(posedge clk);
    // idle fields are junk so nothing may lean on them
    rx_frame <= {1'b0, ~e, ~x, ~f[0], ~f};
  endtask : offer
endmodule : crb1_engine_model
`default_nettype wire

/* File: crb1_ctrl_tb.sv */
// crb1_ctrl_tb: self-checking bench for receive buffer 1 control
// assumes: design, engine model and checker compiled before it
`timescale 1ns/1ps
`default_nettype none
module crb1_ctrl_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, rx_store, buffer_full_flag, buffer0_overflow_enable, irq;
  crb1_pkg::crb1_frame_type rx_frame;
  int n_errors = 0;
  int total_checks = 0;
  always #10 clk = ~clk;
  crb1_ctrl uut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_frame(rx_frame), .rx_store(rx_store),
    .buffer_full_flag(buffer_full_flag), .buffer0_overflow_enable(buffer0_overflow_enable), .irq(irq));
  crb1_engine_model eng (.clk(clk), .rx_frame(rx_frame), .rx_store(rx_store));
  task check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want)
    begin
      n_errors++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, want);
    end
  endtask : check
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do
    begin
      @(posedge clk);
      #1;
    end
    while (avs_waitrequest !== 1'b0);
    @(posedge clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  // writing the control word with bit 7 low frees the buffer first
  task try(input logic [1:0] m, input logic e, input logic x, input logic [2:0] f, input logic w);
    bus(1'b1, crb1_pkg::ctrl_offset, {25'h0, m, 5'h0});
    eng.offer(e, x, f);
    check({31'h0, eng.taken}, {31'h0, w});
    bus(1'b0, crb1_pkg::ctrl_offset, 32'h0);
    if (w) check(rd, {24'h0, 1'b1, m, 1'b0, f[0], f});
  endtask : try
  task reset_values;
    bus(1'b0, crb1_pkg::ctrl_offset, 32'h0);
    check(rd, {24'h0, crb1_pkg::ctrl_reset});
    bus(1'b0, crb1_pkg::irq_status_offset, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, 4'h2, 32'h0);
    check(rd, 32'h0);
  endtask : reset_values
  task modes;
    for (int m = 0; m < 4; m++)
    begin
      try(m[1:0], 1'b0, 1'b0, 3'h2, m != 2);
      try(m[1:0], 1'b0, 1'b1, 3'h4, m != 1);
      try(m[1:0], 1'b1, 1'b0, 3'h5, m == 3);
    end
  endtask : modes
  task filters;
    for (int v = 0; v < 2; v++)
    begin
      bus(1'b1, crb1_pkg::overflow_cfg_offset, v);
      // the write lands on the edge that ends the bus call, so look half a cycle later
      @(negedge clk);
      check({31'h0, buffer0_overflow_enable}, v);
      for (int f = 0; f < 8; f++)
        try(2'h0, 1'b0, f[0], f[2:0], (f[2] ^ f[1]) || (v == 1 && f < 2));
    end
  endtask : filters
  task full_irq;
    try(2'h0, 1'b0, 1'b0, 3'h3, 1'b1);
    bus(1'b1, crb1_pkg::irq_mask_offset, 32'h3);
    eng.offer(1'b0, 1'b0, 3'h5);
    check({31'h0, eng.taken}, 32'h0);
    bus(1'b0, crb1_pkg::ctrl_offset, 32'h0);
    check(rd, 32'h8b);
    bus(1'b0, crb1_pkg::irq_status_offset, 32'h0);
    check(rd, 32'h3);
    check({31'h0, irq}, 32'h1);
    bus(1'b1, crb1_pkg::irq_status_offset, 32'h3);
    @(negedge clk);
    check({31'h0, irq}, 32'h0);
  endtask : full_irq
  task conclude;
    if (n_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude
  initial
  begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    reset_values;
    modes;
    filters;
    full_irq;
    conclude;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    n_errors++;
    conclude;
  end
endmodule : crb1_ctrl_tb
`default_nettype wire
